// ---- verilog/fasp_uart.sv ----
// Serial port core with host register port, baud generator and FIFOs.
// Assumes host strobes and line inputs are synchronous to core_clk.
`timescale 1ns/1ps

module fasp_fifo #(
	parameter int WIDTH = 8,
	parameter int DEPTH = 16,
	parameter int CNT_W = 5
) (
	input  wire logic             core_clk,
	input  wire logic             srst,
	input  wire logic             flush,
	input  wire logic             in_valid,
	output logic                  in_ready,
	input  wire logic [WIDTH-1:0] in_data,
	output logic                  out_valid,
	input  wire logic             out_ready,
	output logic      [WIDTH-1:0] out_data,
	output logic      [CNT_W-1:0] count
);
	localparam int PTR_W = $clog2(DEPTH);
	logic [WIDTH-1:0] mem [DEPTH];
	logic [PTR_W-1:0] wr_ptr;
	logic [PTR_W-1:0] rd_ptr;
	logic             do_push;
	logic             do_pop;

	assign in_ready  = (count != CNT_W'(DEPTH));
	assign out_valid = (count != '0);
	assign out_data  = mem[rd_ptr];
	assign do_push   = in_valid && in_ready;
	assign do_pop    = out_valid && out_ready;

	always_ff @(posedge core_clk) begin
		if (do_push) begin
			mem[wr_ptr] <= in_data;
		end
	end

	always_ff @(posedge core_clk) begin
		if (srst || flush) begin
			wr_ptr <= '0;
			rd_ptr <= '0;
			count  <= '0;
		end else begin
			wr_ptr <= wr_ptr + PTR_W'(do_push);
			rd_ptr <= rd_ptr + PTR_W'(do_pop);
			count  <= count + CNT_W'(do_push) - CNT_W'(do_pop);
		end
	end
endmodule

module fasp_uart
	import fasp_pkg::*;
(
	input  wire logic       core_clk,
	input  wire logic       srst,
	input  wire logic       cs_n,
	input  wire logic       write_strobe_n,
	input  wire logic       read_strobe_n,
	input  wire logic [2:0] register_select,
	input  wire logic [7:0] host_data_bus_in,
	output logic      [7:0] host_data_bus_out,
	output logic            host_data_bus_oe,
	input  wire logic       rx_in,
	output logic            tx_out,
	output logic            rts_n,
	output logic            dtr_n,
	input  wire logic       cts_n,
	input  wire logic       dsr_n,
	input  wire logic       ri_n,
	input  wire logic       cd_n,
	output logic            irq_out,
	output logic            irq_oe,
	output logic            reset_out
);
	fasp_line_fmt_t  line_format_control;
	fasp_modem_ctl_t modem_line_control;
	logic [3:0]      interrupt_enable;
	logic [15:0]     divisor;
	logic [7:0]      scratch;
	logic            fifo_en;
	logic            dma_mode;
	logic [1:0]      tx_trig;
	logic [1:0]      rx_trig;
	logic            wr_n_q;
	logic            rd_n_q;
	logic            wr_pulse;
	logic            rd_pulse;
	logic [7:0]      read_value;
	logic            tx_flush;
	logic            rx_flush;
	logic            tx_push;
	logic            tx_in_ready;
	logic            tx_valid;
	logic            tx_pop_ready;
	logic [7:0]      tx_head;
	logic [4:0]      tx_cnt;
	logic            rx_push;
	logic            rx_room;
	logic            rx_in_ready;
	logic            rx_valid;
	logic            rx_pop;
	fasp_rx_char_t   rx_char;
	fasp_rx_char_t   rx_head;
	logic [4:0]      rx_cnt;
	logic [15:0]     baud_cnt;
	logic            tick;
	fasp_tx_state_t  tx_state;
	logic [7:0]      tx_shift;
	logic [2:0]      tx_bitn;
	logic [5:0]      tx_ticks;
	logic            tx_par;
	logic            tx_line;
	logic [5:0]      stop_ticks;
	logic [2:0]      last_bit;
	logic [7:0]      wmask;
	fasp_rx_state_t  rx_state;
	logic [7:0]      rx_shift;
	logic [2:0]      rx_bitn;
	logic [5:0]      rx_ticks;
	logic            rx_pbit;
	logic            rx_serial;
	logic            rx_prev;
	logic            rx_exp_par;
	logic            overrun;
	logic            fifo_err;
	logic            head_err;
	logic            tx_all_empty;
	logic            tx_empty_q;
	logic            thre_pend;
	logic [3:0]      modem_now;
	logic [3:0]      modem_q;
	logic [3:0]      msr_delta;
	logic [4:0]      rx_level;
	logic            rx_avail;
	logic            line_int;
	logic            rx_int;
	logic            thre_int;
	logic            ms_int;
	logic [3:0]      isr_code;

	function automatic logic [7:0] word_mask(input logic [1:0] wl);
		case (wl)
			2'h0:    word_mask = 8'h1F;
			2'h1:    word_mask = 8'h3F;
			2'h2:    word_mask = 8'h7F;
			default: word_mask = 8'hFF;
		endcase
	endfunction

	// Host strobe edges, chip select gates both
	assign wr_pulse = wr_n_q && !write_strobe_n && !cs_n;
	assign rd_pulse = rd_n_q && !read_strobe_n && !cs_n;
	assign tx_push  = wr_pulse && register_select == ADDR_DATA && !line_format_control.dl_access;
	assign rx_pop   = rd_pulse && register_select == ADDR_DATA && !line_format_control.dl_access;
	assign tx_flush = wr_pulse && register_select == ADDR_ISR
		&& (host_data_bus_in[2] || host_data_bus_in[0] != fifo_en);
	assign rx_flush = wr_pulse && register_select == ADDR_ISR
		&& (host_data_bus_in[1] || host_data_bus_in[0] != fifo_en);

	always_ff @(posedge core_clk) begin
		if (srst) begin
			wr_n_q <= 1'b1;
			rd_n_q <= 1'b1;
		end else begin
			wr_n_q <= write_strobe_n;
			rd_n_q <= read_strobe_n;
		end
	end

	// Register writes
	always_ff @(posedge core_clk) begin
		if (srst) begin
			line_format_control      <= fasp_line_fmt_t'(LCR_RESET);
			modem_line_control      <= fasp_modem_ctl_t'(MCR_RESET);
			interrupt_enable      <= IER_RESET[3:0];
			divisor  <= DIV_RESET;
			scratch  <= SCR_RESET;
			fifo_en  <= 1'b0;
			dma_mode <= 1'b0;
			tx_trig  <= 2'h0;
			rx_trig  <= 2'h0;
		end else if (wr_pulse) begin
			case (register_select)
				ADDR_DATA: begin
					if (line_format_control.dl_access) begin
						divisor[7:0] <= host_data_bus_in;
					end
				end
				ADDR_IER: begin
					if (line_format_control.dl_access) begin
						divisor[15:8] <= host_data_bus_in;
					end else begin
						interrupt_enable <= host_data_bus_in[3:0];
					end
				end
				ADDR_ISR: begin
					fifo_en  <= host_data_bus_in[0];
					dma_mode <= host_data_bus_in[3];
					tx_trig  <= host_data_bus_in[5:4];
					rx_trig  <= host_data_bus_in[7:6];
				end
				ADDR_LCR: line_format_control <= fasp_line_fmt_t'(host_data_bus_in);
				ADDR_MCR: modem_line_control <= fasp_modem_ctl_t'({3'h0, host_data_bus_in[4:0]});
				ADDR_SCR: scratch <= host_data_bus_in;
				default: ;
			endcase
		end
	end

	// Baud generator, 16 ticks per bit
	always_ff @(posedge core_clk) begin
		if (srst || divisor == 16'h0000) begin
			baud_cnt <= 16'h0000;
			tick     <= 1'b0;
		end else if (baud_cnt >= divisor - 16'h0001) begin
			baud_cnt <= 16'h0000;
			tick     <= 1'b1;
		end else begin
			baud_cnt <= baud_cnt + 16'h0001;
			tick     <= 1'b0;
		end
	end

	// Transmit FIFO; modem lines take no part in flow
	assign tx_pop_ready = (tx_state == TX_IDLE);
	fasp_fifo #(.WIDTH(8), .DEPTH(FIFO_DEPTH), .CNT_W(FIFO_CNT_W)) u_tx_fifo (
		.core_clk  (core_clk),
		.srst      (srst),
		.flush     (tx_flush),
		.in_valid  (tx_push),
		.in_ready  (tx_in_ready),
		.in_data   (host_data_bus_in),
		.out_valid (tx_valid),
		.out_ready (tx_pop_ready),
		.out_data  (tx_head),
		.count     (tx_cnt)
	);

	assign wmask      = word_mask(line_format_control.wlen);
	assign last_bit   = {1'b0, line_format_control.wlen} + 3'h4;
	assign stop_ticks = !line_format_control.stop2 ? STOP1_TICKS
		: (line_format_control.wlen == 2'h0 ? STOP15_TICKS : STOP2_TICKS);

	// Transmitter framing
	always_ff @(posedge core_clk) begin
		if (srst) begin
			tx_state <= TX_IDLE;
			tx_shift <= 8'h00;
			tx_bitn  <= 3'h0;
			tx_ticks <= 6'h00;
			tx_par   <= 1'b0;
			tx_line  <= 1'b1;
		end else if (tx_state == TX_IDLE) begin
			if (tx_valid) begin
				tx_shift <= tx_head & wmask;
				tx_par   <= line_format_control.stick_par ? !line_format_control.even_par
					: (line_format_control.even_par ? ^(tx_head & wmask) : ~^(tx_head & wmask));
				tx_state <= TX_START;
				tx_ticks <= 6'h00;
				tx_line  <= 1'b0;
			end
		end else if (tick) begin
			tx_ticks <= tx_ticks + 6'h01;
			case (tx_state)
				TX_START: begin
					if (tx_ticks == BIT_LAST) begin
						tx_state <= TX_DATA;
						tx_ticks <= 6'h00;
						tx_bitn  <= 3'h0;
						tx_line  <= tx_shift[0];
					end
				end
				TX_DATA: begin
					if (tx_ticks == BIT_LAST) begin
						tx_ticks <= 6'h00;
						tx_bitn  <= tx_bitn + 3'h1;
						tx_shift <= {1'b0, tx_shift[7:1]};
						if (tx_bitn != last_bit) begin
							tx_line <= tx_shift[1];
						end else if (line_format_control.par_en) begin
							tx_state <= TX_PARITY;
							tx_line  <= tx_par;
						end else begin
							tx_state <= TX_STOP;
							tx_line  <= 1'b1;
						end
					end
				end
				TX_PARITY: begin
					if (tx_ticks == BIT_LAST) begin
						tx_state <= TX_STOP;
						tx_ticks <= 6'h00;
						tx_line  <= 1'b1;
					end
				end
				TX_STOP: begin
					if (tx_ticks == stop_ticks - 6'h01) begin
						tx_state <= TX_IDLE;
					end
				end
				default: tx_state <= TX_IDLE;
			endcase
		end
	end

	// Line pins and modem outputs
	always_ff @(posedge core_clk) begin
		if (srst) begin
			tx_out    <= 1'b1;
			rts_n     <= 1'b1;
			dtr_n     <= 1'b1;
			reset_out <= 1'b1;
		end else begin
			tx_out    <= modem_line_control.loop ? 1'b1 : (line_format_control.set_break ? 1'b0 : tx_line);
			rts_n     <= !modem_line_control.rts;
			dtr_n     <= !modem_line_control.dtr;
			reset_out <= modem_line_control.out1;
		end
	end

	// Receiver
	assign rx_serial  = modem_line_control.loop ? tx_line : rx_in;
	assign rx_exp_par = line_format_control.stick_par ? !line_format_control.even_par
		: (line_format_control.even_par ? ^rx_shift : ~^rx_shift);
	assign rx_room    = fifo_en ? rx_in_ready : (rx_cnt == 5'h00);

	always_ff @(posedge core_clk) begin
		rx_push <= 1'b0;
		if (srst) begin
			rx_state <= RX_IDLE;
			rx_prev  <= 1'b1;
			rx_shift <= 8'h00;
			rx_bitn  <= 3'h0;
			rx_ticks <= 6'h00;
			rx_pbit  <= 1'b0;
			rx_char  <= '0;
		end else begin
			rx_prev <= rx_serial;
			case (rx_state)
				RX_IDLE: begin
					if (rx_prev && !rx_serial) begin
						rx_state <= RX_START;
						rx_ticks <= 6'h00;
					end
				end
				RX_START: begin
					if (tick) begin
						rx_ticks <= rx_ticks + 6'h01;
						if (rx_ticks == RX_MID_TICKS) begin
							rx_state <= rx_serial ? RX_IDLE : RX_DATA;
							rx_ticks <= 6'h00;
							rx_bitn  <= 3'h0;
							rx_shift <= 8'h00;
						end
					end
				end
				RX_DATA: begin
					if (tick) begin
						rx_ticks <= rx_ticks + 6'h01;
						if (rx_ticks == BIT_LAST) begin
							rx_ticks          <= 6'h00;
							rx_shift[rx_bitn] <= rx_serial;
							rx_bitn           <= rx_bitn + 3'h1;
							if (rx_bitn == last_bit) begin
								rx_state <= line_format_control.par_en ? RX_PARITY : RX_STOP;
							end
						end
					end
				end
				RX_PARITY: begin
					if (tick) begin
						rx_ticks <= rx_ticks + 6'h01;
						if (rx_ticks == BIT_LAST) begin
							rx_ticks <= 6'h00;
							rx_pbit  <= rx_serial;
							rx_state <= RX_STOP;
						end
					end
				end
				RX_STOP: begin
					if (tick) begin
						rx_ticks <= rx_ticks + 6'h01;
						if (rx_ticks == BIT_LAST) begin
							rx_push           <= 1'b1;
							rx_char.data      <= rx_shift;
							rx_char.par_err   <= line_format_control.par_en && rx_pbit != rx_exp_par;
							rx_char.frame_err <= !rx_serial;
							rx_char.brk       <= !rx_serial && rx_shift == 8'h00
								&& !(line_format_control.par_en && rx_pbit);
							rx_state          <= rx_serial ? RX_IDLE : RX_WAIT_HIGH;
						end
					end
				end
				RX_WAIT_HIGH: begin
					if (rx_serial) begin
						rx_state <= RX_IDLE;
					end
				end
				default: rx_state <= RX_IDLE;
			endcase
		end
	end

	fasp_fifo #(.WIDTH($bits(fasp_rx_char_t)), .DEPTH(FIFO_DEPTH), .CNT_W(FIFO_CNT_W)) u_rx_fifo (
		.core_clk  (core_clk),
		.srst      (srst),
		.flush     (rx_flush),
		.in_valid  (rx_push && rx_room),
		.in_ready  (rx_in_ready),
		.in_data   (rx_char),
		.out_valid (rx_valid),
		.out_ready (rx_pop),
		.out_data  (rx_head),
		.count     (rx_cnt)
	);

	// Line status flags, set wins over read clear
	assign head_err     = rx_valid && (rx_head.brk || rx_head.frame_err || rx_head.par_err);
	assign tx_all_empty = !tx_valid && tx_state == TX_IDLE;
	always_ff @(posedge core_clk) begin
		if (srst || rx_flush) begin
			overrun  <= 1'b0;
			fifo_err <= 1'b0;
		end else begin
			overrun  <= (overrun && !(rd_pulse && register_select == ADDR_LSR))
				|| (rx_push && !rx_room);
			fifo_err <= (fifo_err && !(rd_pulse && register_select == ADDR_LSR))
				|| (rx_push && rx_room && fifo_en
				&& (rx_char.brk || rx_char.frame_err || rx_char.par_err));
		end
	end

	// Modem status: inputs active low, loopback uses control bits
	assign modem_now = modem_line_control.loop ? {modem_line_control.out2, modem_line_control.out1, modem_line_control.dtr, modem_line_control.rts}
		: {!cd_n, !ri_n, !dsr_n, !cts_n};
	always_ff @(posedge core_clk) begin
		modem_q <= modem_now;
		if (srst) begin
			msr_delta <= 4'h0;
		end else begin
			msr_delta <= (rd_pulse && register_select == ADDR_MSR ? 4'h0 : msr_delta)
				| {modem_q[3] ^ modem_now[3], modem_q[2] && !modem_now[2],
				modem_q[1] ^ modem_now[1], modem_q[0] ^ modem_now[0]};
		end
	end

	// Interrupt sources in priority order
	always_comb begin
		case (rx_trig)
			2'h0:    rx_level = RX_TRIG_0;
			2'h1:    rx_level = RX_TRIG_1;
			2'h2:    rx_level = RX_TRIG_2;
			default: rx_level = RX_TRIG_3;
		endcase
	end
	assign rx_avail = fifo_en ? (rx_cnt >= rx_level) : rx_valid;
	assign line_int = interrupt_enable[2] && (overrun || head_err);
	assign rx_int   = interrupt_enable[0] && rx_avail;
	assign thre_int = interrupt_enable[1] && thre_pend;
	assign ms_int   = interrupt_enable[3] && (msr_delta != 4'h0);
	assign isr_code = line_int ? ISR_LINE : rx_int ? ISR_RXDATA
		: thre_int ? ISR_THRE : ms_int ? ISR_MODEM : ISR_NONE;

	always_ff @(posedge core_clk) begin
		if (srst) begin
			tx_empty_q <= 1'b1;
			thre_pend  <= 1'b0;
			irq_out    <= 1'b0;
			irq_oe     <= 1'b0;
		end else begin
			tx_empty_q <= !tx_valid;
			thre_pend  <= (thre_pend && !tx_push
				&& !(rd_pulse && register_select == ADDR_ISR && isr_code == ISR_THRE))
				|| (!tx_valid && !tx_empty_q)
				|| (wr_pulse && register_select == ADDR_IER && !line_format_control.dl_access
				&& host_data_bus_in[1] && !interrupt_enable[1] && !tx_valid);
			irq_out    <= line_int || rx_int || thre_int || ms_int;
			irq_oe     <= modem_line_control.out2;
		end
	end

	// Read path
	always_comb begin
		case (register_select)
			ADDR_DATA: read_value = line_format_control.dl_access ? divisor[7:0] : rx_head.data;
			ADDR_IER:  read_value = line_format_control.dl_access ? divisor[15:8] : {4'h0, interrupt_enable};
			ADDR_ISR:  read_value = {fifo_en, fifo_en, rx_valid, tx_in_ready, isr_code};
			ADDR_LCR:  read_value = line_format_control;
			ADDR_MCR:  read_value = modem_line_control;
			ADDR_LSR:  read_value = {fifo_err, tx_all_empty, !tx_valid,
				rx_valid && rx_head.brk, rx_valid && rx_head.frame_err,
				rx_valid && rx_head.par_err, overrun, rx_valid};
			ADDR_MSR:  read_value = {modem_q, msr_delta};
			default:   read_value = scratch;
		endcase
	end

	always_ff @(posedge core_clk) begin
		if (srst) begin
			host_data_bus_out <= 8'h00;
			host_data_bus_oe  <= 1'b0;
		end else begin
			host_data_bus_oe <= !cs_n && !read_strobe_n;
			if (rd_pulse) begin
				host_data_bus_out <= read_value;
			end
		end
	end

	// Checks
	sequence s_mcr_write;
		wr_pulse && register_select == ADDR_MCR;
	endsequence
	sequence s_read_held;
		!cs_n && !read_strobe_n;
	endsequence

	a_reset_tx_mark: assert property (@(posedge core_clk) srst |=> tx_out)
		else $error("tx not mark after reset");
	a_loop_tx_mark: assert property (@(posedge core_clk) disable iff (srst)
		modem_line_control.loop |=> tx_out) else $error("tx not mark in loopback");
	a_rts_follow: assert property (@(posedge core_clk) disable iff (srst)
		s_mcr_write |=> ##1 (rts_n == !$past(host_data_bus_in[1], 2)))
		else $error("rts does not follow control bit");
	a_dtr_follow: assert property (@(posedge core_clk) disable iff (srst)
		s_mcr_write |=> ##1 (dtr_n == !$past(host_data_bus_in[0], 2)))
		else $error("dtr does not follow control bit");
	a_read_drive: assert property (@(posedge core_clk) disable iff (srst)
		s_read_held ##1 s_read_held |-> host_data_bus_oe) else $error("bus not driven");
	a_cs_release: assert property (@(posedge core_clk) disable iff (srst)
		cs_n |=> !host_data_bus_oe) else $error("bus driven without select");
	a_dl_hidden: assert property (@(posedge core_clk) disable iff (srst)
		wr_pulse && register_select == ADDR_DATA && line_format_control.dl_access
		|=> tx_cnt <= $past(tx_cnt)) else $error("divisor write reached tx fifo");
	a_start_check: assert property (@(posedge core_clk) disable iff (srst)
		rx_state == RX_START && tick && rx_ticks == RX_MID_TICKS && rx_serial
		|=> rx_state == RX_IDLE) else $error("false start accepted");
	a_irq_masked: assert property (@(posedge core_clk) disable iff (srst)
		interrupt_enable == 4'h0 ##1 1'b1 |-> !irq_out) else $error("irq with all sources masked");
	a_fifo_bound: assert property (@(posedge core_clk) disable iff (srst)
		tx_cnt <= 5'h10 && rx_cnt <= 5'h10) else $error("fifo count over depth");
	a_cts_status: assert property (@(posedge core_clk) disable iff (srst)
		!modem_line_control.loop && cts_n |=> !modem_q[0]) else $error("cts status wrong");
	a_scratch_keep: assert property (@(posedge core_clk) disable iff (srst)
		(wr_pulse && register_select == ADDR_SCR) ##1 (!wr_pulse)[*3]
		##1 (rd_pulse && register_select == ADDR_SCR)
		|=> host_data_bus_out == $past(host_data_bus_in, 5)) else $error("scratch lost");
endmodule

// ---- verilog/fasp_pkg.sv ----
// Constants, types and state enums for the FIFO serial port.
// Assumes one 20 MHz clock, core_clk, and a synchronous active-high reset.
package fasp_pkg;

	localparam logic [2:0] ADDR_DATA = 3'h0;
	localparam logic [2:0] ADDR_IER  = 3'h1;
	localparam logic [2:0] ADDR_ISR  = 3'h2;
	localparam logic [2:0] ADDR_LCR  = 3'h3;
	localparam logic [2:0] ADDR_MCR  = 3'h4;
	localparam logic [2:0] ADDR_LSR  = 3'h5;
	localparam logic [2:0] ADDR_MSR  = 3'h6;
	localparam logic [2:0] ADDR_SCR  = 3'h7;

	localparam int FIFO_DEPTH = 16;
	localparam int FIFO_CNT_W = 5;

	localparam logic [7:0]  IER_RESET = 8'h00;
	localparam logic [7:0]  LCR_RESET = 8'h00;
	localparam logic [7:0]  MCR_RESET = 8'h00;
	localparam logic [7:0]  SCR_RESET = 8'h00;
	localparam logic [15:0] DIV_RESET = 16'h0000;

	localparam logic [5:0] BIT_LAST      = 6'h0F;
	localparam logic [5:0] RX_MID_TICKS  = 6'h07;
	localparam logic [5:0] STOP1_TICKS   = 6'h10;
	localparam logic [5:0] STOP15_TICKS  = 6'h18;
	localparam logic [5:0] STOP2_TICKS   = 6'h20;

	localparam logic [3:0] ISR_NONE   = 4'h1;
	localparam logic [3:0] ISR_LINE   = 4'h6;
	localparam logic [3:0] ISR_RXDATA = 4'h4;
	localparam logic [3:0] ISR_THRE   = 4'h2;
	localparam logic [3:0] ISR_MODEM  = 4'h0;

	localparam logic [4:0] RX_TRIG_0 = 5'h01;
	localparam logic [4:0] RX_TRIG_1 = 5'h04;
	localparam logic [4:0] RX_TRIG_2 = 5'h08;
	localparam logic [4:0] RX_TRIG_3 = 5'h0E;

	typedef struct packed {
		logic       dl_access;
		logic       set_break;
		logic       stick_par;
		logic       even_par;
		logic       par_en;
		logic       stop2;
		logic [1:0] wlen;
	} fasp_line_fmt_t;

	typedef struct packed {
		logic [2:0] unused;
		logic       loop;
		logic       out2;
		logic       out1;
		logic       rts;
		logic       dtr;
	} fasp_modem_ctl_t;

	typedef struct packed {
		logic       brk;
		logic       frame_err;
		logic       par_err;
		logic [7:0] data;
	} fasp_rx_char_t;

	typedef enum logic [2:0] {TX_IDLE, TX_START, TX_DATA, TX_PARITY, TX_STOP} fasp_tx_state_t;
	typedef enum logic [2:0] {
		RX_IDLE, RX_START, RX_DATA, RX_PARITY, RX_STOP, RX_WAIT_HIGH
	} fasp_rx_state_t;

endpackage

// ---- testbench/fasp_host_model.sv ----
// Host CPU model driving the parallel register port.
// Assumes core_clk runs freely; requests change 1 ns after a rising edge.
`timescale 1ns/1ps
module fasp_host_model (
	input  wire logic       core_clk,
	output logic            cs_n,
	output logic            write_strobe_n,
	output logic            read_strobe_n,
	output logic      [2:0] register_select,
	output logic      [7:0] host_data_bus_in,
	input  wire logic [7:0] host_data_bus_out,
	input  wire logic       host_data_bus_oe
);
	initial begin
		cs_n = 1'b1;
		write_strobe_n = 1'b1;
		read_strobe_n = 1'b1;
		register_select = 3'h0;
		host_data_bus_in = 8'hA5;
	end
	// Write cycle, sel_n high gives a deselected access
	task automatic wr(input logic [2:0] a, input logic [7:0] d, input logic sel_n);
		@(posedge core_clk);
		#1;
		cs_n = sel_n;
		write_strobe_n = 1'b0;
		register_select = a;
		host_data_bus_in = d;
		@(posedge core_clk);
		#1;
		cs_n = 1'b1;
		write_strobe_n = 1'b1;
		host_data_bus_in = ~d;
	endtask
	// Read cycle, data taken while strobe still low
	task automatic rd(input logic [2:0] a, output logic [7:0] d, output logic oe);
		@(posedge core_clk);
		#1;
		cs_n = 1'b0;
		read_strobe_n = 1'b0;
		register_select = a;
		@(posedge core_clk);
		@(posedge core_clk);
		#1;
		d = host_data_bus_out;
		oe = host_data_bus_oe;
		cs_n = 1'b1;
		read_strobe_n = 1'b1;
	endtask
endmodule

// ---- testbench/testbench.sv ----
// Self-checking bench for the serial port core.
// Assumes divisor 1, so one bit lasts 16 clocks.
`timescale 1ns/1ps
module testbench;
	import fasp_pkg::*;
	logic        core_clk, srst, cs_n, write_strobe_n, read_strobe_n, rx_in, tx_out;
	logic        rts_n, dtr_n, cts_n, dsr_n, ri_n, cd_n, irq_out, irq_oe, reset_out;
	logic [2:0]  register_select;
	logic [7:0]  host_data_bus_in, host_data_bus_out, d, v;
	logic        host_data_bus_oe, oe;
	logic [31:0] seed;
	logic [9:0]  frame;
	logic [7:0]  exp_q[$];
	int          fails, num_checks, cyc, lows;
	fasp_uart i_fasp_uart (.core_clk(core_clk), .srst(srst), .cs_n(cs_n),
		.write_strobe_n(write_strobe_n), .read_strobe_n(read_strobe_n),
		.register_select(register_select), .host_data_bus_in(host_data_bus_in),
		.host_data_bus_out(host_data_bus_out), .host_data_bus_oe(host_data_bus_oe),
		.rx_in(rx_in), .tx_out(tx_out), .rts_n(rts_n), .dtr_n(dtr_n), .cts_n(cts_n),
		.dsr_n(dsr_n), .ri_n(ri_n), .cd_n(cd_n), .irq_out(irq_out), .irq_oe(irq_oe),
		.reset_out(reset_out));
	fasp_host_model host (.core_clk(core_clk), .cs_n(cs_n), .write_strobe_n(write_strobe_n),
		.read_strobe_n(read_strobe_n), .register_select(register_select),
		.host_data_bus_in(host_data_bus_in), .host_data_bus_out(host_data_bus_out),
		.host_data_bus_oe(host_data_bus_oe));
	always #25 core_clk = ~core_clk;
	function automatic logic [7:0] xs();
		seed ^= seed << 13;
		seed ^= seed >> 17;
		seed ^= seed << 5;
		return seed[7:0];
	endfunction
	task automatic chk(input logic [7:0] got, input logic [7:0] exp);
		num_checks++;
		if (got !== exp) begin
			fails++;
			$display("[ERR] %0t got %h expected %h", $time, got, exp);
		end
	endtask
	task automatic wrap_up();
		$display("checks %0d fails %0d", num_checks, fails);
		if (fails == 0 && num_checks > 0)
			$display("All checks passed");
		else
			$display("Checks failed");
		$finish;
	endtask
	task automatic cycles(input int n);
		repeat (n) @(posedge core_clk);
		#1;
	endtask
	always @(posedge core_clk) begin
		cyc++;
		if (cyc == 6000) begin
			fails++;
			wrap_up();
		end
	end
	initial begin
		core_clk = 1'b0;
		srst = 1'b1;
		rx_in = 1'b1;
		seed = 32'd34653;
		{cd_n, ri_n, dsr_n, cts_n} = 4'hF;
		cycles(2);
		chk({irq_out, irq_oe, host_data_bus_oe, tx_out, rts_n, dtr_n, reset_out}, 8'h0F);
		srst = 1'b0;
		for (int i = 0; i < 4; i++) begin
			v = xs();
			host.wr(ADDR_SCR, v, 1'b0);
			host.wr(ADDR_SCR, ~v, 1'b1);
			host.rd(ADDR_SCR, d, oe);
			chk(d, v);
			chk(oe, 1);
			cycles(1);
			chk(host_data_bus_oe, 0);
			{cd_n, ri_n, dsr_n, cts_n} = v[3:0];
			host.rd(ADDR_MSR, d, oe);
			chk({4'h0, d[7:4]}, {4'h0, ~v[3:0]});
		end
		for (int k = 0; k < 5; k++) begin
			v = 8'h0F & (8'h01 << k);
			host.wr(ADDR_MCR, v, 1'b0);
			cycles(2);
			chk({rts_n, dtr_n, reset_out, irq_oe}, {~v[1], ~v[0], v[2], v[3]});
		end
		host.wr(ADDR_IER, 8'h05, 1'b0);
		host.wr(ADDR_LCR, 8'h83, 1'b0);
		host.wr(ADDR_DATA, 8'h01, 1'b0);
		host.wr(ADDR_IER, 8'h00, 1'b0);
		host.rd(ADDR_DATA, d, oe);
		chk(d, 8'h01);
		host.rd(ADDR_IER, d, oe);
		chk(d, 8'h00);
		host.wr(ADDR_LCR, 8'h03, 1'b0);
		host.rd(ADDR_IER, d, oe);
		chk(d, 8'h05);
		host.rd(ADDR_LCR, d, oe);
		chk(d, 8'h03);
		host.wr(ADDR_MCR, 8'h10, 1'b0);
		rx_in = 1'b0;
		for (int i = 0; i < 2; i++) begin
			v = xs();
			exp_q.push_back(v);
			host.wr(ADDR_DATA, v, 1'b0);
			lows = 0;
			repeat (220) begin
				cycles(1);
				lows += (tx_out !== 1'b1);
			end
			chk(lows, 0);
			host.rd(ADDR_DATA, d, oe);
			chk(d, exp_q.pop_front());
		end
		rx_in = 1'b1;
		host.wr(ADDR_MCR, 8'h00, 1'b0);
		v = xs();
		host.wr(ADDR_DATA, v, 1'b0);
		for (int n = 0; n < 50 && tx_out === 1'b1; n++)
			cycles(1);
		cycles(8);
		chk(tx_out, 0);
		for (int b = 0; b < 9; b++) begin
			cycles(16);
			chk(tx_out, b < 8 ? v[b] : 1'b1);
		end
		v = xs();
		rx_in = 1'b0;
		cycles(4);
		rx_in = 1'b1;
		cycles(40);
		frame = {1'b1, v, 1'b0};
		for (int b = 0; b < 10; b++) begin
			rx_in = frame[b];
			cycles(16);
		end
		cycles(4);
		chk(irq_out, 1);
		host.rd(ADDR_DATA, d, oe);
		chk(d, v);
		host.rd(ADDR_LSR, d, oe);
		chk(d[0], 0);
		chk(irq_out, 0);
		wrap_up();
	end
endmodule
